// [logic/sps_pkg.sv]
// sync serial port shared types and constants
package sps_pkg;
   localparam int         SPS_MAX_BITS     = 16;
   localparam int         SPS_FIFO_DEPTH   = 8;
   localparam int         SPS_BUF_DEPTH    = 2;
   localparam logic [3:0] SPS_HALF_LVL     = 4'h4;
   localparam logic [3:0] SPS_MIN_SIZE_M1  = 4'h3;
   localparam logic [7:0] SPS_MIN_HALF_DIV = 8'h04;
   localparam logic [6:0] SPS_RX_TMO_CYC   = 7'h40;

   typedef enum logic [1:0] {
      SPS_FMT_SPI = 2'h0,
      SPS_FMT_SSI = 2'h1,
      SPS_FMT_3W  = 2'h2
   } sps_fmt_t;

   typedef enum logic [1:0] {
      SPS_ST_IDLE  = 2'h0,
      SPS_ST_LEAD  = 2'h1,
      SPS_ST_SHIFT = 2'h2,
      SPS_ST_GAP   = 2'h3
   } sps_state_t;

   typedef struct packed {
      logic       master;
      sps_fmt_t   fmt;
      logic       cpol;
      logic       cpha;
      logic [3:0] size_m1;
      logic [7:0] half_div;
   } sps_cfg_t;

   typedef struct packed {
      logic sel;
      logic miso;
      logic mosi;
   } sps_pin_in_t;

   typedef struct packed {
      logic sclk_o;
      logic sclk_oe;
      logic sel_o;
      logic sel_oe;
      logic miso_o;
      logic miso_oe;
      logic mosi_o;
      logic mosi_oe;
   } sps_pin_out_t;

   typedef struct packed {
      logic busy;
      logic tx_half_empty;
      logic rx_half_full;
      logic rx_timeout;
      logic rx_overrun;
   } sps_stat_t;
endpackage

// [logic/sps_fifo.sv]
// parameterised valid/ready fifo, depth a power of two
`timescale 1ns/10ps
module sps_fifo #(
   parameter  int W     = 16,
   parameter  int DEPTH = 8,
   localparam int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1,
   localparam int CW    = $clog2(DEPTH + 1)
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          rstn,
   // fill side
   input  wire logic          in_valid,
   input  wire logic [W-1:0]  in_data,
   output logic               in_ready,
   // drain side
   output logic               out_valid,
   output logic [W-1:0]       out_data,
   input  wire logic          out_ready,
   // fill level
   output logic [CW-1:0]      count
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
   } sps_fifo_st_t;

   sps_fifo_st_t q_q;
   sps_fifo_st_t q_d;
   logic         push;
   logic         pop;

   assign in_ready  = (q_q.cnt != CW'(DEPTH));
   assign out_valid = (q_q.cnt != '0);
   assign out_data  = q_q.mem[q_q.rp];
   assign count     = q_q.cnt;

   always_comb begin
      q_d  = q_q;
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      if (push) begin
         q_d.mem[q_q.wp] = in_data;
         q_d.wp          = AW'(q_q.wp + 1'b1);
      end
      if (pop) begin
         q_d.rp = AW'(q_q.rp + 1'b1);
      end
      if (push && !pop) begin
         q_d.cnt = CW'(q_q.cnt + 1'b1);
      end else if (pop && !push) begin
         q_d.cnt = CW'(q_q.cnt - 1'b1);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   a_fifo_bound : assert property (@(posedge clock) disable iff (!rstn)
      q_q.cnt <= CW'(DEPTH)) else $error("fifo count above depth");
   c_fifo_full : cover property (@(posedge clock) disable iff (!rstn) !in_ready);
endmodule

// [logic/sps_top.sv]
// sync serial port: master/slave engine, frame queues, slave link domain
`timescale 1ns/10ps
module sps_top (
   // system clock and reset
   input  wire logic                               clock,
   input  wire logic                               rstn,
   // serial clock received as slave
   input  wire logic                               link_sclk,
   // configuration and control
   input  wire sps_pkg::sps_cfg_t                  cfg,
   input  wire logic                               overrun_clr,
   // transmit frames in
   input  wire logic                               tx_valid,
   input  wire logic [sps_pkg::SPS_MAX_BITS-1:0]   tx_data,
   output logic                                    tx_ready,
   // receive frames out
   output logic                                    rx_valid,
   output logic [sps_pkg::SPS_MAX_BITS-1:0]        rx_data,
   input  wire logic                               rx_ready,
   // status and interrupt
   output sps_pkg::sps_stat_t                      stat,
   output logic                                    irq,
   // serial pins
   input  wire sps_pkg::sps_pin_in_t               pin_i,
   output sps_pkg::sps_pin_out_t                   pin_o
);
   localparam int MB = sps_pkg::SPS_MAX_BITS;

   typedef struct packed {
      logic                miso_s1;
      logic                miso_s2;
      logic                tgl_s1;
      logic                tgl_s2;
      logic                tgl_seen;
      sps_pkg::sps_state_t st;
      logic [7:0]          div;
      logic [4:0]          edges;
      logic                sclk;
      logic                sel;
      logic                mosi;
      logic [MB-1:0]       tx_sh;
      logic [MB-1:0]       rx_sh;
      logic                push;
      logic [MB-1:0]       word;
      logic [MB-1:0]       slv_tx;
      logic                slv_loaded;
      logic                oe_m;
      logic                ovr;
      logic [6:0]          tmo_cnt;
      logic                tmo;
      logic                tx_he;
      logic                rx_hf;
      logic                busy;
      logic                irq;
   } sps_sys_t;

   typedef struct packed {
      logic [4:0]    cnt;
      logic          act;
      logic [MB-1:0] rx_sh;
      logic [MB-1:0] hold;
      logic          tgl;
   } sps_lnk_t;

   function automatic logic [3:0] eff_size(input sps_pkg::sps_cfg_t c);
      return (c.size_m1 < sps_pkg::SPS_MIN_SIZE_M1) ? sps_pkg::SPS_MIN_SIZE_M1 : c.size_m1;
   endfunction

   function automatic logic is_ssi(input sps_pkg::sps_cfg_t c);
      return c.fmt == sps_pkg::SPS_FMT_SSI;
   endfunction

   function automatic logic eff_cpol(input sps_pkg::sps_cfg_t c);
      return (c.fmt == sps_pkg::SPS_FMT_SPI) ? c.cpol : 1'b0;
   endfunction

   function automatic logic eff_cpha(input sps_pkg::sps_cfg_t c);
      logic r;
      r = c.cpha;
      unique case (c.fmt)
         sps_pkg::SPS_FMT_SPI: r = c.cpha;
         sps_pkg::SPS_FMT_SSI: r = 1'b1;
         sps_pkg::SPS_FMT_3W:  r = 1'b0;
         default:              r = c.cpha;
      endcase
      return r;
   endfunction

   function automatic logic sel_pin(input sps_pkg::sps_cfg_t c, input logic active);
      return is_ssi(c) ? active : !active;
   endfunction

   sps_sys_t s_q;
   sps_sys_t s_d;
   sps_lnk_t l_q;
   sps_lnk_t l_d;
   logic     miso_q;

   logic          txf_valid;
   logic [MB-1:0] txf_data;
   logic          txf_pop;
   logic [3:0]    txf_cnt;
   logic          buf_ready;
   logic          buf_valid;
   logic [MB-1:0] buf_data;
   logic          rxf_in_ready;
   logic [3:0]    rxf_cnt;
   logic [3:0]    size;
   logic [7:0]    half;
   logic          expire;
   logic          slv_sel;
   logic          capture;

   sps_fifo #(.W(MB), .DEPTH(sps_pkg::SPS_FIFO_DEPTH)) u_txf (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (tx_valid),
      .in_data   (tx_data),
      .in_ready  (tx_ready),
      .out_valid (txf_valid),
      .out_data  (txf_data),
      .out_ready (txf_pop),
      .count     (txf_cnt)
   );

   // two-entry buffer between the shifter and the receive queue
   sps_fifo #(.W(MB), .DEPTH(sps_pkg::SPS_BUF_DEPTH)) u_buf (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (s_q.push),
      .in_data   (s_q.word),
      .in_ready  (buf_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (rxf_in_ready),
      .count     ()
   );

   sps_fifo #(.W(MB), .DEPTH(sps_pkg::SPS_FIFO_DEPTH)) u_rxf (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (buf_valid),
      .in_data   (buf_data),
      .in_ready  (rxf_in_ready),
      .out_valid (rx_valid),
      .out_data  (rx_data),
      .out_ready (rx_ready),
      .count     (rxf_cnt)
   );

   assign size   = eff_size(cfg);
   assign half   = (cfg.half_div < sps_pkg::SPS_MIN_HALF_DIV) ? sps_pkg::SPS_MIN_HALF_DIV : cfg.half_div;
   assign expire = (s_q.div >= 8'(half - 8'h01));

   // system domain: master engine, slave word handover, status
   always_comb begin
      s_d         = s_q;
      txf_pop     = 1'b0;
      s_d.miso_s1 = pin_i.miso;
      s_d.miso_s2 = s_q.miso_s1;
      s_d.tgl_s1  = l_q.tgl;
      s_d.tgl_s2  = s_q.tgl_s1;
      s_d.push    = 1'b0;
      s_d.oe_m    = cfg.master;
      s_d.div     = (s_q.st == sps_pkg::SPS_ST_IDLE || expire) ? 8'h00 : 8'(s_q.div + 8'h01);
      unique case (s_q.st)
         sps_pkg::SPS_ST_IDLE: begin
            s_d.sclk = eff_cpol(cfg);
            s_d.sel  = sel_pin(cfg, 1'b0);
            // no frame starts unless the buffer can take its answer
            if (cfg.master && txf_valid && buf_ready) begin
               txf_pop   = 1'b1;
               s_d.tx_sh = txf_data;
               s_d.mosi  = txf_data[size];
               s_d.rx_sh = '0;
               s_d.edges = 5'h00;
               s_d.sel   = sel_pin(cfg, 1'b1);
               s_d.st    = sps_pkg::SPS_ST_LEAD;
            end
         end
         sps_pkg::SPS_ST_LEAD: begin
            if (expire) begin
               if (is_ssi(cfg)) begin
                  // frame pulse spans one whole clock period ahead of the data
                  s_d.sclk  = !s_q.sclk;
                  s_d.edges = 5'(s_q.edges + 5'h01);
                  if (s_q.edges == 5'h01) begin
                     s_d.sel   = sel_pin(cfg, 1'b0);
                     s_d.edges = 5'h00;
                     s_d.st    = sps_pkg::SPS_ST_SHIFT;
                  end
               end else begin
                  s_d.st = sps_pkg::SPS_ST_SHIFT;
               end
            end
         end
         sps_pkg::SPS_ST_SHIFT: begin
            if (expire) begin
               s_d.sclk  = !s_q.sclk;
               s_d.edges = 5'(s_q.edges + 5'h01);
               if (s_q.edges[0] == eff_cpha(cfg)) begin
                  s_d.rx_sh = {s_q.rx_sh[MB-2:0], s_q.miso_s2};
               end else if (s_q.edges != 5'h00) begin
                  s_d.tx_sh = {s_q.tx_sh[MB-2:0], 1'b0};
                  s_d.mosi  = s_d.tx_sh[size];
               end
               if (s_q.edges == {size, 1'b1}) begin
                  s_d.push = 1'b1;
                  s_d.word = s_d.rx_sh;
                  // select drops one cycle later: the far side's last sample edge stays qualified
                  s_d.st   = sps_pkg::SPS_ST_GAP;
               end
            end
         end
         sps_pkg::SPS_ST_GAP: begin
            s_d.sel = sel_pin(cfg, 1'b0);
            if (expire) begin
               s_d.st = sps_pkg::SPS_ST_IDLE;
            end
         end
      endcase
      if (!cfg.master) begin
         s_d.st   = sps_pkg::SPS_ST_IDLE;
         s_d.sclk = eff_cpol(cfg);
      end
      // slave frame finished in the link domain
      if (s_q.tgl_s2 != s_q.tgl_seen) begin
         s_d.tgl_seen   = s_q.tgl_s2;
         s_d.push       = 1'b1;
         s_d.word       = l_q.hold;
         s_d.slv_tx     = '0;
         s_d.slv_loaded = 1'b0;
      end else if (!cfg.master && !s_q.slv_loaded && txf_valid) begin
         txf_pop        = 1'b1;
         s_d.slv_tx     = txf_data;
         s_d.slv_loaded = 1'b1;
      end
      // a word the buffer cannot take is lost; set wins over clear
      s_d.ovr = (s_q.push && !buf_ready) || (s_q.ovr && !overrun_clr);
      if (!rx_valid || rx_ready || buf_valid) begin
         s_d.tmo_cnt = 7'h00;
      end else if (s_q.tmo_cnt != sps_pkg::SPS_RX_TMO_CYC) begin
         s_d.tmo_cnt = 7'(s_q.tmo_cnt + 7'h01);
      end
      s_d.tmo   = (s_d.tmo_cnt == sps_pkg::SPS_RX_TMO_CYC);
      s_d.tx_he = (txf_cnt <= sps_pkg::SPS_HALF_LVL);
      s_d.rx_hf = (rxf_cnt >= sps_pkg::SPS_HALF_LVL);
      s_d.busy  = (s_d.st != sps_pkg::SPS_ST_IDLE);
      s_d.irq   = s_d.tx_he || s_d.rx_hf || s_d.tmo || s_d.ovr;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // link domain: slave shifter clocked by the master's serial clock
   assign capture = is_ssi(cfg) ? l_q.act : !pin_i.sel;

   always_comb begin
      l_d = l_q;
      if (cfg.master) begin
         l_d.cnt = 5'h00;
         l_d.act = 1'b0;
      end else if (capture) begin
         l_d.rx_sh = {l_q.rx_sh[MB-2:0], pin_i.mosi};
         if (l_q.cnt == {1'b0, size}) begin
            l_d.hold  = l_d.rx_sh;
            l_d.tgl   = !l_q.tgl;
            l_d.cnt   = 5'h00;
            l_d.act   = 1'b0;
            l_d.rx_sh = '0;
         end else begin
            l_d.cnt = 5'(l_q.cnt + 5'h01);
         end
      end else if (is_ssi(cfg) && pin_i.sel) begin
         l_d.act = 1'b1;
         l_d.cnt = 5'h00;
      end else begin
         l_d.cnt   = 5'h00;
         l_d.rx_sh = '0;
      end
   end

   always_ff @(posedge link_sclk or negedge rstn) begin
      if (!rstn) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // slave output moves on the opposite edge so it is stable at the sample edge
   always_ff @(negedge link_sclk or negedge rstn) begin
      if (!rstn) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= s_q.slv_tx[4'(size - l_q.cnt[3:0])];
      end
   end

   // outside ssi the enable follows the select pin directly: an unselected slave must let go at once; ssi holds it through l_q.act
   assign slv_sel = is_ssi(cfg) ? (pin_i.sel || l_q.act) : !pin_i.sel;

   assign pin_o.sclk_o  = s_q.sclk;
   assign pin_o.sclk_oe = s_q.oe_m;
   assign pin_o.sel_o   = s_q.sel;
   assign pin_o.sel_oe  = s_q.oe_m;
   assign pin_o.mosi_o  = s_q.mosi;
   assign pin_o.mosi_oe = s_q.oe_m;
   assign pin_o.miso_o  = (l_q.cnt == 5'h00) ? s_q.slv_tx[size] : miso_q;
   assign pin_o.miso_oe = !s_q.oe_m && !cfg.master && slv_sel;

   assign stat.busy          = s_q.busy;
   assign stat.tx_half_empty = s_q.tx_he;
   assign stat.rx_half_full  = s_q.rx_hf;
   assign stat.rx_timeout    = s_q.tmo;
   assign stat.rx_overrun    = s_q.ovr;
   assign irq                = s_q.irq;

   a_sclk_idle : assert property (@(posedge clock) disable iff (!rstn)
      (s_q.st == sps_pkg::SPS_ST_GAP) |-> (s_q.sclk == eff_cpol(cfg))) else $error("clock not idle in gap");
   a_ssi_clk_low : assert property (@(posedge clock) disable iff (!rstn)
      (cfg.fmt != sps_pkg::SPS_FMT_SPI && s_q.st == sps_pkg::SPS_ST_GAP) |-> !s_q.sclk)
      else $error("clock not low outside spi");
   a_sel_release : assert property (@(posedge clock) disable iff (!rstn)
      (s_q.st == sps_pkg::SPS_ST_GAP) |=> (s_q.sel == sel_pin(cfg, 1'b0))) else $error("select held after data");
   a_sel_level : assert property (@(posedge clock) disable iff (!rstn)
      (s_q.st == sps_pkg::SPS_ST_SHIFT && !is_ssi(cfg)) |-> (s_q.sel == sel_pin(cfg, 1'b1)))
      else $error("select wrong level during frame");
   a_frame_push : assert property (@(posedge clock) disable iff (!rstn)
      (s_q.st == sps_pkg::SPS_ST_SHIFT) ##1 (s_q.st == sps_pkg::SPS_ST_GAP) |-> s_q.push)
      else $error("frame ended without received word");
   a_master_pins : assert property (@(posedge clock) disable iff (!rstn)
      s_q.oe_m |-> (pin_o.sclk_oe && pin_o.mosi_oe && !pin_o.miso_oe)) else $error("master pin drive wrong");
   a_miso_hiz : assert property (@(posedge clock) disable iff (!rstn)
      (!cfg.master && !is_ssi(cfg) && pin_i.sel) |-> !pin_o.miso_oe) else $error("unselected slave drives miso");
   a_ovr_set : assert property (@(posedge clock) disable iff (!rstn)
      (s_q.push && !buf_ready) |=> (s_q.ovr && s_q.irq)) else $error("overrun not flagged");
   a_end_idle : assert property (@(posedge clock) disable iff (!rstn)
      (s_q.st == sps_pkg::SPS_ST_GAP && !txf_valid && cfg.master) |-> ##[1:260] (s_q.st == sps_pkg::SPS_ST_IDLE))
      else $error("transfer not ended on empty queue");
   a_link_count : assert property (@(posedge link_sclk) disable iff (!rstn)
      l_q.cnt <= {1'b0, size}) else $error("slave bit count beyond frame");
   a_slave_word : assert property (@(posedge link_sclk) disable iff (!rstn)
      (!cfg.master && capture && l_q.cnt == {1'b0, size}) |=> (l_q.tgl != $past(l_q.tgl)))
      else $error("slave frame not published");

   c_master_frame : cover property (@(posedge clock) disable iff (!rstn) s_q.push && cfg.master);
   c_slave_frame : cover property (@(posedge clock) disable iff (!rstn) s_q.push && !cfg.master);
   c_overrun : cover property (@(posedge clock) disable iff (!rstn) $rose(s_q.ovr));
   c_timeout : cover property (@(posedge clock) disable iff (!rstn) $rose(s_q.tmo));
endmodule

// [bench/sps_slave_model.sv]
// serial slave model answering the port while it is bus master
`timescale 1ns/10ps
module sps_slave_model (
   // bus pins
   input  wire logic        sclk,
   input  wire logic        sel,
   input  wire logic        mosi,
   output logic             miso,
   // mode
   input  wire logic        en,
   input  wire logic [1:0]  fmt,
   input  wire logic        cpol,
   input  wire logic        cpha,
   input  wire logic [3:0]  size,
   input  wire logic [15:0] rep,
   // word taken in
   output logic [15:0]      got
);
   logic       act;
   logic       arm;
   logic       lvl;
   logic       out;
   logic [4:0] k;
   logic [4:0] ns;
   initial begin
      act = 0;
      arm = 0;
      out = 0;
      k = 0;
      ns = 0;
      got = 0;
   end
   // a released line shows the inverse of the last bit, never a kept value
   assign miso = act ? out : ~out;
   // sampling level: ssi falls, three-wire rises, spi by phase
   assign lvl = (fmt == 2'h1) ? 1'b0 : (fmt == 2'h2) ? 1'b1 : ~(cpol ^ cpha);
   always @(negedge sel) if (en && fmt != 2'h1) begin
      act = 1;
      got = 0;
      k = 0;
      if (fmt == 2'h2 || !cpha) begin
         out = rep[size];
         k = 1;
      end
   end
   always @(posedge sel) if (fmt != 2'h1) act = 0;
   always @(sclk) if (en) begin
      if (fmt == 2'h1 && sclk && sel && !act) begin
         arm = 1;
      end else if (arm && !sclk) begin
         arm = 0;
         act = 1;
         k = 0;
         ns = 0;
         got = 0;
      end else if (act && sclk == lvl) begin
         got = {got[14:0], mosi};
         ns = ns + 1;
         if (fmt == 2'h1 && ns == size + 1) act = 0;
      end else if (act && k <= size) begin
         out = rep[size - k];
         k = k + 1;
      end
   end
endmodule

// [bench/tb_sync_serial_port.sv]
// testbench: master frames against a slave model, slave frames from the bench
`timescale 1ns/10ps
module tb_sync_serial_port;
   logic                  clock;
   logic                  rstn;
   logic                  link_sclk;
   sps_pkg::sps_cfg_t     cfg;
   logic                  overrun_clr;
   logic                  tx_valid;
   logic [15:0]           tx_data;
   logic                  tx_ready;
   logic                  rx_valid;
   logic [15:0]           rx_data;
   logic                  rx_ready;
   sps_pkg::sps_stat_t    stat;
   logic                  irq;
   sps_pkg::sps_pin_in_t  pin_i;
   sps_pkg::sps_pin_out_t pin_o;
   logic                  sclk_w;
   logic                  m_sel;
   logic                  m_mosi;
   logic                  p_miso;
   logic [15:0]           rep;
   logic [15:0]           got;
   logic [15:0]           msk;
   logic [7:0]            tab [6];
   logic [7:0]            r;
   logic                  idl_chk;
   int                    mismatches;
   int                    total_checks;
   int                    cyc;
   int                    n;

   sps_top dut_u (.clock(clock), .rstn(rstn), .link_sclk(link_sclk), .cfg(cfg), .overrun_clr(overrun_clr),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .stat(stat), .irq(irq), .pin_i(pin_i), .pin_o(pin_o));

   // one slave only on this bus, so its select needs no extra qualification
   sps_slave_model part_u (.sclk(sclk_w), .sel(pin_i.sel), .mosi(pin_i.mosi), .miso(p_miso), .en(cfg.master),
      .fmt(cfg.fmt), .cpol(cfg.cpol), .cpha(cfg.cpha), .size(cfg.size_m1), .rep(rep), .got(got));

   assign pin_i.sel  = pin_o.sel_oe ? pin_o.sel_o : m_sel;
   assign pin_i.miso = pin_o.miso_oe ? pin_o.miso_o : p_miso;
   assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi_o : m_mosi;
   assign sclk_w     = pin_o.sclk_oe ? pin_o.sclk_o : link_sclk;

   always #12.5 clock = ~clock;

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         $display("[ERR] %0t run hung", $time);
         test_done();
      end
   end

   task automatic chk(input logic [15:0] a, input logic [15:0] e, input string m);
      total_checks++;
      if (a !== e) begin
         mismatches++;
         $display("[ERR] %0t %s: %h not %h", $time, m, a, e);
      end
   endtask

   task automatic till_rx();
      int k;
      k = 0;
      while (rx_valid !== 1'b1 && k < 600) begin
         @(negedge clock);
         k++;
         if (idl_chk && pin_o.sel_o === 1'b1) chk(pin_o.sclk_o, cfg.cpol, "clock outside frame");
      end
      chk(rx_valid, 1, "no word back");
   endtask

   // bench as external master, mode 0, link clock runs only inside the frame
   task automatic frame(input logic [7:0] d, output logic [7:0] q);
      m_sel = 0;
      for (int b = 7; b >= 0; b--) begin
         m_mosi = d[b];
         #7.5;
         // latch just ahead of the rising edge, never in the step that moves the slave
         q[b] = pin_o.miso_o;
         if (b == 7) chk(pin_o.miso_oe, 1, "selected slave silent");
         link_sclk = 1;
         #7.5 link_sclk = 0;
      end
      #7.5 m_sel = 1;
      m_mosi = ~m_mosi;
   endtask

   initial begin
      clock = 0;
      rstn = 0;
      link_sclk = 0;
      overrun_clr = 0;
      tx_valid = 0;
      tx_data = 0;
      rx_ready = 0;
      m_sel = 1;
      m_mosi = 0;
      rep = 0;
      idl_chk = 0;
      mismatches = 0;
      total_checks = 0;
      cyc = 0;
      cfg = '{master: 1'b1, fmt: sps_pkg::SPS_FMT_SPI, cpol: 1'b0, cpha: 1'b0, size_m1: 4'h7, half_div: 8'h04};
      // fmt, cpol, cpha, bits minus one
      tab = '{8'h07, 8'h23, 8'h1F, 8'h38, 8'h4B, 8'h84};
      repeat (4) @(negedge clock);
      chk(tx_ready, 1, "tx ready in reset");
      chk(rx_valid, 0, "rx valid in reset");
      rstn = 1;
      @(negedge clock);
      chk(pin_o.sel_o, 1, "idle select");
      chk(pin_o.sclk_oe, 1, "master clock off");
      chk(irq, 1, "empty tx irq");
      chk(stat.tx_half_empty, 1, "empty tx not half empty");
      for (int i = 0; i < 6; i++) begin
         cfg.fmt = sps_pkg::sps_fmt_t'(tab[i][7:6]);
         cfg.cpol = tab[i][5];
         cfg.cpha = tab[i][4];
         cfg.size_m1 = tab[i][3:0];
         msk = 16'hFFFF >> (4'hF - tab[i][3:0]);
         rep = 16'hB4E1 ^ 16'(i);
         idl_chk = (tab[i][7:6] != 2'h1);
         @(negedge clock);
         tx_valid = 1;
         tx_data = 16'h6D29 + 16'(i);
         @(negedge clock);
         tx_valid = 0;
         till_rx();
         idl_chk = 0;
         chk(rx_data, rep & msk, "master rx word");
         chk(got, tx_data & msk, "slave got word");
         repeat (60) @(negedge clock);
         chk(stat.rx_timeout, 0, "early timeout");
         chk(stat.busy, 0, "still busy");
         chk(pin_o.sel_o, tab[i][7:6] != 2'h1, "select level");
         // ssi and three-wire entries carry cpol 0, their fixed idle level
         chk(pin_o.sclk_o, cfg.cpol, "clock idle level");
         repeat (10) @(negedge clock);
         chk(stat.rx_timeout, 1, "no timeout");
         rx_ready = 1;
         @(negedge clock);
         rx_ready = 0;
      end
      cfg = '{master: 1'b0, fmt: sps_pkg::SPS_FMT_SPI, cpol: 1'b0, cpha: 1'b0, size_m1: 4'h7, half_div: 8'h04};
      repeat (2) @(negedge clock);
      chk(pin_o.miso_oe, 0, "unselected drive");
      chk(pin_o.sclk_oe, 0, "slave drives clock");
      chk(pin_o.sel_oe, 0, "slave drives select");
      // the slave word register takes one entry, the queue the other eight
      tx_valid = 1;
      for (int i = 0; i < 9; i++) begin
         tx_data = 16'h00F0 + 16'(i);
         @(negedge clock);
      end
      tx_valid = 0;
      chk(tx_ready, 0, "tx queue not full");
      chk(irq, 0, "spurious irq");
      chk(stat.tx_half_empty, 0, "full tx half empty");
      for (int f = 0; f < 11; f++) begin
         #3;
         frame(8'hC0 + 8'(f), r);
         chk({8'h00, r}, (f < 9) ? 16'h00F0 + 16'(f) : 16'h0000, "slave sent");
         repeat (8) @(negedge clock);
      end
      chk(stat.rx_overrun, 1, "overrun missed");
      chk(stat.rx_half_full, 1, "half full missed");
      chk(irq, 1, "irq missed");
      rx_ready = 1;
      n = 0;
      while (rx_valid === 1'b1 && n < 12) begin
         chk(rx_data, 16'h00C0 + 16'(n), "slave rx word");
         @(negedge clock);
         n++;
      end
      rx_ready = 0;
      chk(16'(n), 16'h000A, "stored words");
      overrun_clr = 1;
      @(negedge clock);
      overrun_clr = 0;
      @(negedge clock);
      chk(stat.rx_overrun, 0, "overrun stuck");
      test_done();
   end
endmodule
